// [hw/wake_irq_ctrl.sv]
// wakeup, power mode and interrupt control block
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module wake_irq_ctrl
   import wake_irq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // register port
   input wire reg_req_t reg_i,
   output logic [7:0] rdata_o,
   // interrupt events, one-cycle pulses from on-chip logic
   input wire irq_events_t events_i,
   // timer 0 overflow pulse and run bit from the timer
   input wire logic t0_overflow_i,
   input wire logic timer_zero_run_i,
   // high oscillator clock tick, one-cycle pulse
   input wire logic hosc_tick_i,
   // wake pins, asynchronous
   input wire logic port0_pin_i,
   input wire logic [5:0] port1_pin_i,
   // core handshake
   input wire logic instr_boundary_i,
   input wire logic return_from_irq_i,
   output logic irq_take_o,
   output logic [15:0] vector_o,
   output logic cpu_run_o,
   output logic low_clock_select_o,
   output logic high_osc_halt_o,
   output logic [1:0] cpu_mode_o,
   output logic [2:0] stack_level_o
);
   // reset release chain
   logic rst_meta_q;
   logic rst_sync_q;
   // pin synchronisers and previous sample
   logic [6:0] pin_meta_q;
   logic [6:0] pin_sync_q;
   logic [6:0] pin_prev_q;
   // registers
   logic [5:0] port1_pin_wake_bits_q;
   logic [7:0] flags_q;
   logic [7:0] en_q;
   logic global_irq_enable_q;
   logic [2:0] stack_q;
   logic [1:0] mode_q;
   logic low_clock_select_q;
   logic high_osc_halt_q;
   // power state and settling count
   power_state_t state_q;
   logic [11:0] settle_q;
   // decoded strobes and wake terms
   logic wr_mode;
   logic [6:0] pin_change;
   logic pin_wake;
   logic take;
   logic [7:0] set_bits;

   // reset released through two flip-flops
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   // two-flop sync of wake pins, then one more for change detect
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         pin_meta_q <= 7'h00;
         pin_sync_q <= 7'h00;
         pin_prev_q <= 7'h00;
      end
      else
      begin
         pin_meta_q <= {port1_pin_i, port0_pin_i};
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   // level change on port 0 always wakes, port 1 only where enabled
   assign pin_change = pin_sync_q ^ pin_prev_q;
   assign pin_wake = pin_change[0] | (|(pin_change[6:1] & port1_pin_wake_bits_q)); // RQ11 RQ12

   // mode register write strobe
   assign wr_mode = reg_i.wr && (reg_i.addr == ADDR_OSC_CTRL);

   // take: pending and enabled, global enable set, core at boundary and running
   assign take = global_irq_enable_q && (|(flags_q & en_q & IRQ_MASK)) && instr_boundary_i
      && (state_q == ST_RUN); // RQ17 RQ23 RQ24

   // events collected at their flag positions
   always_comb
   begin
      set_bits = 8'h00;
      set_bits[BIT_PIN] = events_i.pin; // RQ13
      set_bits[BIT_T0] = events_i.t0;
      set_bits[BIT_TC0] = events_i.tc0;
   end

   // port 1 wake enables, write-only
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         port1_pin_wake_bits_q <= P1_WAKE_RESET; // RQ12
      end
      else if (reg_i.wr && (reg_i.addr == ADDR_P1_WAKE))
      begin
         port1_pin_wake_bits_q <= reg_i.wdata[5:0]; // RQ12
      end
   end

   // request flags: events set regardless of enable, set beats clear
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         flags_q <= 8'h00;
      end
      else if (reg_i.wr && (reg_i.addr == ADDR_IRQ_FLAGS))
      begin
         flags_q <= (reg_i.wdata | set_bits) & IRQ_MASK; // RQ22
      end
      else
      begin
         flags_q <= flags_q | set_bits; // RQ21 RQ23
      end
   end

   // enable bits
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         en_q <= 8'h00;
      end
      else if (reg_i.wr && (reg_i.addr == ADDR_IRQ_EN))
      begin
         en_q <= reg_i.wdata & IRQ_MASK; // RQ20
      end
   end

   // global enable and stack level
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         global_irq_enable_q <= 1'b0;
         stack_q <= STACK_RESET;
      end
      else if (take)
      begin
         // entering service blocks further requests
         global_irq_enable_q <= 1'b0; // RQ15
         stack_q <= stack_q - 3'h1; // RQ18
      end
      else if (return_from_irq_i)
      begin
         global_irq_enable_q <= 1'b1; // RQ16
         stack_q <= stack_q + 3'h1; // RQ19
      end
      else if (reg_i.wr && (reg_i.addr == ADDR_STACK))
      begin
         global_irq_enable_q <= reg_i.wdata[BIT_GIE];
         stack_q <= reg_i.wdata[2:0];
      end
   end

   // vector request to the core, one cycle
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         irq_take_o <= 1'b0;
         vector_o <= 16'h0000;
      end
      else
      begin
         irq_take_o <= take; // RQ18
         vector_o <= take ? VECTOR_ADDR : 16'h0000; // RQ24
      end
   end

   // oscillator control fields
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         low_clock_select_q <= 1'b0;
         high_osc_halt_q <= 1'b0;
      end
      else if (wr_mode)
      begin
         // software keeps slow mode for the oscillator restart delay
         low_clock_select_q <= reg_i.wdata[BIT_LOWCLK]; // RQ2 RQ4
         high_osc_halt_q <= reg_i.wdata[BIT_HALT];
      end
      else if (state_q == ST_SETTLE && settle_q == SETTLE_LAST && hosc_tick_i)
      begin
         // sleep always returns to the high clock
         low_clock_select_q <= 1'b0; // RQ7
         high_osc_halt_q <= 1'b0;
      end
   end

   // power state machine and mode field
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         state_q <= ST_RUN;
         mode_q <= MODE_NORMAL;
         settle_q <= 12'h000;
      end
      else
      begin
         unique case (state_q)
            ST_RUN:
            begin
               settle_q <= 12'h000;
               if (wr_mode)
               begin
                  mode_q <= reg_i.wdata[BIT_MODE_LO+1:BIT_MODE_LO];
                  // reserved code 11 keeps running
                  if (reg_i.wdata[BIT_MODE_LO+1:BIT_MODE_LO] == MODE_SLEEP)
                  begin
                     state_q <= ST_SLEEP; // RQ1
                  end
                  else if (reg_i.wdata[BIT_MODE_LO+1:BIT_MODE_LO] == MODE_GREEN)
                  begin
                     state_q <= ST_GREEN; // RQ1
                  end
               end
            end
            ST_GREEN:
            begin
               // pins always, timer only with its run bit set
               if (pin_wake || (t0_overflow_i && timer_zero_run_i)) // RQ5 RQ6 RQ8
               begin
                  // no settling, slow select untouched, core resumes next instruction
                  state_q <= ST_RUN; // RQ10 RQ25
                  mode_q <= MODE_NORMAL;
               end
            end
            ST_SLEEP:
            begin
               // only external triggers leave sleep
               if (pin_wake) // RQ3 RQ7 RQ14
               begin
                  state_q <= ST_SETTLE;
                  settle_q <= 12'h000;
               end
            end
            ST_SETTLE:
            begin
               if (hosc_tick_i)
               begin
                  if (settle_q == SETTLE_LAST) // RQ9
                  begin
                     state_q <= ST_RUN;
                     mode_q <= MODE_NORMAL; // RQ7
                  end
                  else
                  begin
                     settle_q <= settle_q + 12'h001;
                  end
               end
            end
         endcase
      end
   end

   // register read data, one cycle after the strobe
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         rdata_o <= 8'h00;
      end
      else if (reg_i.rd)
      begin
         unique case (reg_i.addr)
            ADDR_IRQ_FLAGS: rdata_o <= flags_q;
            ADDR_IRQ_EN: rdata_o <= en_q;
            ADDR_OSC_CTRL: rdata_o <= {3'h0, mode_q, low_clock_select_q, high_osc_halt_q, 1'b0};
            ADDR_STACK: rdata_o <= {global_irq_enable_q, 4'h0, stack_q};
            default: rdata_o <= 8'h00;
         endcase
      end
      else
      begin
         rdata_o <= 8'h00;
      end
   end

   // status outputs to the core and clock logic
   always_ff @(posedge clk_sys_i or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
      begin
         cpu_run_o <= 1'b1;
         low_clock_select_o <= 1'b0;
         high_osc_halt_o <= 1'b0;
         cpu_mode_o <= MODE_NORMAL;
         stack_level_o <= STACK_RESET;
      end
      else
      begin
         cpu_run_o <= (state_q == ST_RUN);
         low_clock_select_o <= low_clock_select_q; // RQ2
         high_osc_halt_o <= high_osc_halt_q | (state_q == ST_SLEEP) | (state_q == ST_SETTLE);
         cpu_mode_o <= mode_q;
         stack_level_o <= stack_q;
      end
   end
endmodule
`default_nettype wire

// [hw/wake_irq_pkg.sv]
// constants, types and the contract list for the wakeup and interrupt controller
// Contract
// RQ1 - mode field: 00 normal, 01 sleep, 10 green
// RQ2 - low clock select picks slow clock
// RQ3 - sleep exits only on wake pin or reset
// RQ4 - software waits 20ms before leaving slow
// RQ5 - green without timer wake: pins or reset
// RQ6 - green with timer wake: pins, reset, timer
// RQ7 - sleep wakeup lands in normal, external only
// RQ8 - green wakeup restores previous normal or slow
// RQ9 - sleep wakeup waits 2048 oscillator clocks
// RQ10 - green wakeup resumes without settling delay
// RQ11 - port 0 wakeup always enabled
// RQ12 - six write-only port 1 wake enables
// RQ13 - three sources: pin, timer, timer/counter
// RQ14 - pin interrupt wakes sleep into normal
// RQ15 - service entry clears global enable
// RQ16 - service exit sets global enable
// RQ17 - no interrupt unless global enable is one
// RQ18 - accept pushes stack, vectors to 8
// RQ19 - return from irq pops stack
// RQ20 - enable bits 0, 4, 5, reset zero
// RQ21 - events set flags at bits 0, 4, 5
// RQ22 - software clears flags, never hardware
// RQ23 - flags set even when disabled
// RQ24 - several pending requests share vector 8
// RQ25 - green wake resumes after entering instruction
package wake_irq_pkg;
   // register offsets
   localparam logic [7:0] ADDR_P1_WAKE = 8'hc0;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hc8;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hc9;
   localparam logic [7:0] ADDR_OSC_CTRL = 8'hca;
   localparam logic [7:0] ADDR_STACK = 8'hdf;
   // field positions
   localparam int BIT_PIN = 0;
   localparam int BIT_T0 = 4;
   localparam int BIT_TC0 = 5;
   localparam int BIT_GIE = 7;
   localparam int BIT_HALT = 1;
   localparam int BIT_LOWCLK = 2;
   localparam int BIT_MODE_LO = 3;
   // masks and reset values
   localparam logic [7:0] IRQ_MASK = 8'h31;
   localparam logic [5:0] P1_WAKE_RESET = 6'h00;
   localparam logic [2:0] STACK_RESET = 3'h7;
   localparam logic [15:0] VECTOR_ADDR = 16'h0008;
   // mode field encodings
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_SLEEP = 2'h1;
   localparam logic [1:0] MODE_GREEN = 2'h2;
   // oscillator settling, in high oscillator clocks
   localparam int SETTLE_CLOCKS = 2048;
   localparam logic [11:0] SETTLE_LAST = 12'(SETTLE_CLOCKS - 1);
   // core power state
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_GREEN = 2'b01,
      ST_SLEEP = 2'b11,
      ST_SETTLE = 2'b10
   } power_state_t;
   // register bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   // interrupt sources as events
   typedef struct packed {
      logic pin;
      logic t0;
      logic tc0;
   } irq_events_t;
endpackage

// [verif/wake_irq_ctrl_chk.sv]
// bound checker for the wakeup and interrupt controller ports
`timescale 1ns/1ps
`default_nettype none
module wake_irq_ctrl_chk
   import wake_irq_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // inputs watched
   input wire reg_req_t reg_i,
   input wire logic hosc_tick_i,
   input wire logic return_from_irq_i,
   input wire logic instr_boundary_i,
   // outputs watched
   input wire logic [7:0] rdata_o,
   input wire logic irq_take_o,
   input wire logic [15:0] vector_o,
   input wire logic cpu_run_o,
   input wire logic [1:0] cpu_mode_o,
   input wire logic [2:0] stack_level_o
);
   logic [12:0] tick_q; // oscillator ticks since the core stopped
   logic sleep_q; // core stopped in sleep, not green
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   // count ticks and remember sleep while halted
   always_ff @(posedge clk_sys_i)
   begin
      if (cpu_run_o)
      begin
         tick_q <= '0;
         sleep_q <= 1'b0;
      end
      else
      begin
         tick_q <= tick_q + 13'(hosc_tick_i);
         sleep_q <= sleep_q | (cpu_mode_o == MODE_SLEEP);
      end
   end
   a_vector_on_take: assert property (vector_o == (irq_take_o ? VECTOR_ADDR : 16'h0000))
      else $error("vector wrong");
   a_take_pushes: assert property (irq_take_o |=> stack_level_o == $past(stack_level_o) - 3'h1)
      else $error("stack not pushed");
   a_take_blocks: assert property (irq_take_o |=> !irq_take_o)
      else $error("second take");
   a_take_boundary: assert property (irq_take_o |-> $past(instr_boundary_i))
      else $error("take off boundary");
   a_return_pops: assert property (return_from_irq_i |-> ##2 stack_level_o == $past(stack_level_o, 2) + 3'h1)
      else $error("stack not popped");
   a_wo_reads_zero: assert property (reg_i.rd && reg_i.addr == ADDR_P1_WAKE |=> rdata_o == 8'h00)
      else $error("write-only read");
   a_enable_bits: assert property (reg_i.rd && reg_i.addr == ADDR_IRQ_EN |=> (rdata_o & ~IRQ_MASK) == 8'h00)
      else $error("enable spare bits");
   a_sleep_halts: assert property (reg_i.wr && reg_i.addr == ADDR_OSC_CTRL && reg_i.wdata[4:3] == MODE_SLEEP
      |-> ##2 !cpu_run_o)
      else $error("sleep not entered");
   a_reserved_runs: assert property (reg_i.wr && reg_i.addr == ADDR_OSC_CTRL && reg_i.wdata[4:3] == 2'h3
      && cpu_run_o |-> ##2 cpu_run_o)
      else $error("reserved mode stopped");
   a_settle_count: assert property ($rose(cpu_run_o) && sleep_q |-> tick_q inside {[13'd2049:13'd2050]})
      else $error("settling count wrong");
endmodule
bind wake_irq_ctrl wake_irq_ctrl_chk i_wake_irq_ctrl_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
   .reg_i(reg_i), .hosc_tick_i(hosc_tick_i), .return_from_irq_i(return_from_irq_i),
   .instr_boundary_i(instr_boundary_i), .rdata_o(rdata_o), .irq_take_o(irq_take_o), .vector_o(vector_o),
   .cpu_run_o(cpu_run_o), .cpu_mode_o(cpu_mode_o), .stack_level_o(stack_level_o));
`default_nettype wire

// [verif/core_model.sv]
// core side model: instruction boundaries and return from interrupt
`timescale 1ns/1ps
`default_nettype none
module core_model
(
   // clock and block outputs
   input wire logic clk_sys_i,
   input wire logic irq_take_i,
   input wire logic cpu_run_i,
   // handshake into the block
   output logic instr_boundary_o,
   output logic return_from_irq_o = 1'b0
);
   logic [3:0] svc_q = 4'h0; // cycles left in the service routine
   // every running cycle ends an instruction
   assign instr_boundary_o = cpu_run_i;
   // service routine lasts a fixed time, then returns
   always @(posedge clk_sys_i)
   begin
      return_from_irq_o <= (svc_q == 4'h1);
      if (irq_take_i)
         svc_q <= 4'hc;
      else if (svc_q != 4'h0)
         svc_q <= svc_q - 4'h1;
   end
endmodule
`default_nettype wire

// [verif/wake_irq_ctrl_tb.sv]
// self-checking bench for the wakeup and interrupt controller
`timescale 1ns/1ps
`default_nettype none
module wake_irq_ctrl_tb;
   import wake_irq_pkg::*;
   // register write and expected read-back
   typedef struct packed { logic [7:0] a, d, e; } row_t;
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   reg_req_t reg_i = '0;
   irq_events_t events_i = '0;
   logic t0_ovf = 1'b0, t0_run = 1'b0, tick = 1'b0, p0 = 1'b0;
   logic [5:0] p1 = 6'h00;
   logic bnd, ret, take, run, lclk, halt;
   logic [7:0] rdata;
   logic [15:0] vec;
   logic [1:0] mode;
   logic [2:0] stk;
   int error_cnt = 0, n_checks = 0, cyc = 0, takes = 0;
   row_t rows [5] = '{'{8'hc9, 8'hff, 8'h31}, '{8'hc8, 8'h00, 8'h00}, '{8'hc0, 8'h3e, 8'h00},
      '{8'hc1, 8'h5a, 8'h00}, '{8'hdf, 8'h07, 8'h07}};
   // design and core model
   wake_irq_ctrl i_wake_irq_ctrl (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .reg_i(reg_i), .rdata_o(rdata),
      .events_i(events_i), .t0_overflow_i(t0_ovf), .timer_zero_run_i(t0_run), .hosc_tick_i(tick),
      .port0_pin_i(p0), .port1_pin_i(p1), .instr_boundary_i(bnd), .return_from_irq_i(ret),
      .irq_take_o(take), .vector_o(vec), .cpu_run_o(run), .low_clock_select_o(lclk),
      .high_osc_halt_o(halt), .cpu_mode_o(mode), .stack_level_o(stk));
   core_model i_core_model (.clk_sys_i(clk_sys_i), .irq_take_i(take), .cpu_run_i(run),
      .instr_boundary_o(bnd), .return_from_irq_o(ret));
   // clock
   initial forever #2.5 clk_sys_i = ~clk_sys_i;
   // verdict and end of run
   task automatic report_and_stop();
      if (error_cnt == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // value compare
   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one-cycle register write
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_sys_i);
      reg_i <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys_i);
      reg_i <= '0;
   endtask
   // one-cycle register read, data in the next cycle
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk_sys_i);
      reg_i <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys_i);
      reg_i <= '0;
      #1 chk(rdata, e);
   endtask
   // bounded wait for the run level
   task automatic wait_run(input logic v, input int n);
      repeat (n) if (run !== v) @(negedge clk_sys_i);
      chk(run, v);
   endtask
   // cycle ceiling and take counter
   always @(posedge clk_sys_i)
   begin
      cyc++;
      takes += int'(take);
      if (cyc == 10000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (4) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk({run, stk}, 16'hf);
      rd(ADDR_IRQ_EN, 8'h00);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      rd(ADDR_STACK, 8'h07);
      rd(ADDR_OSC_CTRL, 8'h00);
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      // events set flags with enables off
      wr(ADDR_IRQ_EN, 8'h00);
      @(posedge clk_sys_i) events_i <= '1;
      @(posedge clk_sys_i) events_i <= '0;
      rd(ADDR_IRQ_FLAGS, 8'h31);
      wr(ADDR_IRQ_FLAGS, 8'h11);
      rd(ADDR_IRQ_FLAGS, 8'h11);
      // enabled requests wait for the global enable, then one take
      wr(ADDR_IRQ_EN, IRQ_MASK);
      repeat (4) @(negedge clk_sys_i);
      chk(takes, 0);
      wr(ADDR_STACK, 8'h87);
      rd(ADDR_STACK, 8'h06);
      chk(takes, 1);
      wr(ADDR_IRQ_FLAGS, 8'h00);
      repeat (16) @(negedge clk_sys_i);
      chk(takes, 1);
      rd(ADDR_STACK, 8'h87);
      // sleep ignores disabled pin and timer, port 0 wakes after settling
      wr(ADDR_OSC_CTRL, 8'h08);
      wait_run(1'b0, 4);
      @(posedge clk_sys_i) p1 <= 6'h01;
      t0_run <= 1'b1;
      t0_ovf <= 1'b1;
      @(posedge clk_sys_i) t0_ovf <= 1'b0;
      repeat (10) @(negedge clk_sys_i);
      chk({run, mode}, 16'h1);
      @(posedge clk_sys_i) p0 <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      tick <= 1'b1;
      wait_run(1'b1, 2100);
      chk({lclk, mode}, 16'h0);
      @(posedge clk_sys_i) tick <= 1'b0;
      // slow, then green woken by timer only when it runs
      wr(ADDR_OSC_CTRL, 8'h04);
      wr(ADDR_OSC_CTRL, 8'h14);
      chk(lclk, 1'b1);
      wait_run(1'b0, 4);
      @(posedge clk_sys_i) t0_run <= 1'b0;
      t0_ovf <= 1'b1;
      @(posedge clk_sys_i) t0_ovf <= 1'b0;
      repeat (8) @(negedge clk_sys_i);
      chk(run, 1'b0);
      @(posedge clk_sys_i) t0_run <= 1'b1;
      t0_ovf <= 1'b1;
      @(posedge clk_sys_i) t0_ovf <= 1'b0;
      wait_run(1'b1, 6);
      chk({lclk, mode}, 16'h4);
      // oscillator never stopped, so normal needs no wait; reserved code keeps running
      wr(ADDR_OSC_CTRL, 8'h18);
      repeat (4) @(negedge clk_sys_i);
      chk({run, halt}, 16'h2);
      // second reset in mid-run clears the enables again
      @(posedge clk_sys_i) nrst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      chk({run, stk}, 16'hf);
      rd(ADDR_IRQ_EN, 8'h00);
      report_and_stop();
   end
endmodule
`default_nettype wire
